// ===== logic/klt_defs.svh
`ifndef KLT_DEFS_SVH
`define KLT_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define KLT_OFS_TIMEOUT 8'h00
`define KLT_OFS_CODE 8'h04
`define KLT_OFS_STATUS 8'h08
`define KLT_OFS_IRQ_STAT 8'h0c
`define KLT_OFS_IRQ_MASK 8'h10

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define KLT_ST_IDLE_LSB 0
`define KLT_ST_LOCK_LSB 7
`define KLT_ST_RUN_LSB 9
`define KLT_ST_MSG_LSB 10

// ---------------------------------------------------------------
// interrupt bits
// ---------------------------------------------------------------
`define KLT_IRQ_MESSAGE_A 0
`define KLT_IRQ_TIMEOUT 1
`define KLT_IRQ_LOCK_ON 2
`define KLT_IRQ_LOCK_OFF 3

// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define KLT_RST_TIMEOUT 7'h00
`define KLT_RST_CODE 16'h1000
`define KLT_MAX_TIMEOUT 7'h63
`define KLT_CODE_DIGITS 2'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define KLT_CLK_KHZ 125000
`define KLT_TICK_MS 1000
`define KLT_MSG_TICKS 2'h2

`endif

// ===== logic/klt_pkg.sv
package klt_pkg;

    typedef enum logic [2:0] {
        KEY_DIGIT, KEY_START, KEY_STOP, KEY_ENTER, KEY_CLEAR, KEY_POINT, KEY_MENU
    } klt_key_fn_type;

    typedef enum logic [1:0] {LK_UNLOCKED, LK_CODE, LK_TIMEOUT} klt_lock_type;

    typedef enum logic [2:0] {
        MSG_NONE, MSG_A, MSG_SECURITY, MSG_LOCK_ON, MSG_LOCK_OFF
    } klt_msg_type;

    typedef enum logic [1:0] {ITEM_BATCH, ITEM_WARN, ITEM_OTHER} klt_item_type;

    typedef struct packed {
        logic valid;
        klt_key_fn_type fn;
        logic [3:0] digit;
    } klt_key_type;

    typedef struct packed {
        logic valid;
        logic write;
        klt_item_type item;
    } klt_menu_req_type;

    typedef struct packed {
        logic grant;
        logic deny;
    } klt_menu_ans_type;

    typedef struct packed {
        logic [31:0] tick_cnt;
        logic tick;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [6:0] idle_timeout_seconds;
        logic [15:0] code;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic irq;
        klt_lock_type lock;
        logic running;
        logic [6:0] idle;
        klt_msg_type msg;
        logic [1:0] msg_left;
        logic [1:0] dcnt;
        logic [15:0] dbuf;
        klt_key_type key_out;
        klt_menu_ans_type ans;
    } klt_state_type;

endpackage : klt_pkg

// ===== logic/klt_top.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`include "klt_defs.svh"

module klt_top #(
    parameter int unsigned TICK_CYCLES = `KLT_TICK_MS * `KLT_CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run_mode,
    input wire logic pulse_in,
    input wire klt_pkg::klt_key_type key_in,
    input wire klt_pkg::klt_menu_req_type menu_req,
    output klt_pkg::klt_key_type key_out,
    output klt_pkg::klt_menu_ans_type menu_ans,
    output klt_pkg::klt_msg_type msg,
    output klt_pkg::klt_lock_type lock,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import klt_pkg::*;

    klt_state_type s;
    klt_state_type n;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [3:0] ev;
        logic [3:0] clr;
        logic [31:0] wv;
        logic [15:0] cand;
        ev = 4'h0;
        clr = 4'h0;
        wv = 32'h0;
        cand = 16'h0;
        n = s;
        n.tick = 1'b0;
        n.key_out = '0;
        n.ans = '0;

        // one-second time base
        if (s.tick_cnt >= TICK_CYCLES - 1) begin
            n.tick_cnt = 32'h0;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = s.tick_cnt + 32'h1;
        end

        // write channel
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (n.aw_got && n.w_got && !n.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = 2'h0;
            case (n.awaddr)
                `KLT_OFS_TIMEOUT: begin
                    wv = wmerge({25'h0, s.idle_timeout_seconds}, n.wdata, n.wstrb);
                    if (wv <= {25'h0, `KLT_MAX_TIMEOUT}) begin
                        n.idle_timeout_seconds = wv[6:0];
                    end else begin
                        n.bresp = 2'h2;
                    end
                end
                `KLT_OFS_CODE: begin
                    wv = wmerge({16'h0, s.code}, n.wdata, n.wstrb);
                    n.code = wv[15:0];
                end
                `KLT_OFS_IRQ_STAT: begin
                    wv = wmerge(32'h0, n.wdata, n.wstrb);
                    clr = wv[3:0];
                end
                `KLT_OFS_IRQ_MASK: begin
                    wv = wmerge({28'h0, s.irq_mask}, n.wdata, n.wstrb);
                    n.irq_mask = wv[3:0];
                end
                `KLT_OFS_STATUS: n.bresp = 2'h0;
                default: n.bresp = 2'h2;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        // read channel
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = 2'h0;
            n.rdata = 32'h0;
            case (s_axi_araddr)
                `KLT_OFS_TIMEOUT: n.rdata = {25'h0, s.idle_timeout_seconds};
                `KLT_OFS_CODE: n.rdata = {16'h0, s.code};
                `KLT_OFS_STATUS: begin
                    n.rdata[`KLT_ST_IDLE_LSB +: 7] = s.idle;
                    n.rdata[`KLT_ST_LOCK_LSB +: 2] = s.lock;
                    n.rdata[`KLT_ST_RUN_LSB] = s.running;
                    n.rdata[`KLT_ST_MSG_LSB +: 3] = s.msg;
                end
                `KLT_OFS_IRQ_STAT: n.rdata = {28'h0, s.irq_stat};
                `KLT_OFS_IRQ_MASK: n.rdata = {28'h0, s.irq_mask};
                default: n.rresp = 2'h2;
            endcase
        end
        n.arready = !n.rvalid;

        // brief messages expire
        if (s.tick && s.msg_left != 2'h0) begin
            n.msg_left = s.msg_left - 2'h1;
            if (s.msg_left == 2'h1 && s.msg != MSG_SECURITY) begin
                n.msg = MSG_NONE;
            end
        end

        // keypad
        if (key_in.valid && (s.lock != LK_TIMEOUT || key_in.fn == KEY_DIGIT)) begin
            n.key_out = key_in;
            case (key_in.fn)
                KEY_DIGIT: begin
                    if (run_mode || s.lock != LK_UNLOCKED) begin
                        cand = {s.dbuf[11:0], key_in.digit};
                        if (s.dcnt == `KLT_CODE_DIGITS) begin
                            n.dcnt = 2'h0;
                            n.dbuf = 16'h0;
                            if (cand == s.code) begin
                                n.msg_left = `KLT_MSG_TICKS;
                                case (s.lock)
                                    LK_TIMEOUT: begin
                                        n.lock = LK_UNLOCKED;
                                        n.msg = MSG_NONE;
                                    end
                                    LK_CODE: begin
                                        n.lock = LK_UNLOCKED;
                                        n.msg = MSG_LOCK_OFF;
                                        ev[`KLT_IRQ_LOCK_OFF] = 1'b1;
                                    end
                                    default: begin
                                        n.lock = LK_CODE;
                                        n.msg = MSG_LOCK_ON;
                                        ev[`KLT_IRQ_LOCK_ON] = 1'b1;
                                    end
                                endcase
                            end
                        end else begin
                            n.dcnt = s.dcnt + 2'h1;
                            n.dbuf = cand;
                        end
                    end
                end
                KEY_START: begin
                    n.dcnt = 2'h0;
                    if (run_mode) begin
                        n.running = 1'b1;
                        n.msg = MSG_A;
                        n.msg_left = `KLT_MSG_TICKS;
                        ev[`KLT_IRQ_MESSAGE_A] = 1'b1;
                    end
                end
                KEY_STOP: begin
                    n.dcnt = 2'h0;
                    n.running = 1'b0;
                end
                default: n.dcnt = 2'h0;
            endcase
        end

        // menu access filter
        if (menu_req.valid) begin
            case (s.lock)
                LK_UNLOCKED: n.ans.grant = 1'b1;
                LK_CODE: begin
                    case (menu_req.item)
                        ITEM_BATCH: n.ans.grant = 1'b1;
                        ITEM_WARN: begin
                            n.ans.grant = !menu_req.write;
                            n.ans.deny = menu_req.write;
                        end
                        default: n.ans.deny = 1'b1;
                    endcase
                end
                default: n.ans.deny = 1'b1;
            endcase
        end

        // idle timer
        if (pulse_in) begin
            n.idle = 7'h0;
        end else if (s.tick && s.running && s.idle_timeout_seconds != 7'h0) begin
            if (s.idle + 7'h1 >= s.idle_timeout_seconds) begin
                n.lock = LK_TIMEOUT;
                n.running = 1'b0;
                n.idle = 7'h0;
                n.dcnt = 2'h0;
                n.msg = MSG_SECURITY;
                ev[`KLT_IRQ_TIMEOUT] = 1'b1;
            end else begin
                n.idle = s.idle + 7'h1;
            end
        end

        // sticky interrupt status, set wins over clear
        n.irq_stat = (s.irq_stat & ~clr) | ev;
        n.irq = |(n.irq_stat & n.irq_mask);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.idle_timeout_seconds <= `KLT_RST_TIMEOUT;
            s.code <= `KLT_RST_CODE;
            s.lock <= LK_UNLOCKED;
            s.msg <= MSG_NONE;
        end else begin
            s <= n;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign key_out = s.key_out;
    assign menu_ans = s.ans;
    assign msg = s.msg;
    assign lock = s.lock;
    assign irq = s.irq;
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence start_press;
        key_in.valid && key_in.fn == KEY_START && run_mode && s.lock != LK_TIMEOUT;
    endsequence

    sequence message_a_shown;
        s.running && s.msg == MSG_A && s.irq_stat[`KLT_IRQ_MESSAGE_A];
    endsequence

    chk_reset_values: assert property ($fell(sys_rst) |->
        s.idle_timeout_seconds == 7'h0 && s.code == 16'h1000 && s.lock == LK_UNLOCKED)
        else $error("reset values wrong");

    chk_pulse_clears: assert property (pulse_in |=> s.idle == 7'h0)
        else $error("pulse did not clear idle count");

    chk_idle_frozen: assert property (!s.running && !pulse_in |=> $stable(s.idle))
        else $error("idle count moved while stopped");

    chk_zero_disables: assert property (
        s.idle_timeout_seconds == 7'h0 && s.lock != LK_TIMEOUT |=> s.lock != LK_TIMEOUT)
        else $error("timeout lock with timeout off");

    chk_timeout_locks: assert property (
        s.tick && s.running && !pulse_in && s.idle_timeout_seconds != 7'h0
        && s.idle + 7'h1 >= s.idle_timeout_seconds
        |=> s.lock == LK_TIMEOUT && s.msg == MSG_SECURITY && !s.running)
        else $error("idle timeout did not lock");

    chk_keys_ignored: assert property (
        s.lock == LK_TIMEOUT && key_in.valid && key_in.fn != KEY_DIGIT |=> !key_out.valid)
        else $error("non-digit key passed under timeout lock");

    chk_batch_open: assert property (
        s.lock == LK_CODE && menu_req.valid && menu_req.item == ITEM_BATCH
        |=> menu_ans.grant && !menu_ans.deny)
        else $error("batch target refused under code lock");

    chk_warn_readonly: assert property (
        s.lock == LK_CODE && menu_req.valid && menu_req.item == ITEM_WARN
        |=> menu_ans.deny == $past(menu_req.write) && menu_ans.grant == !$past(menu_req.write))
        else $error("early-warning access wrong under code lock");

    chk_other_refused: assert property (
        s.lock == LK_CODE && menu_req.valid && menu_req.item == ITEM_OTHER |=> menu_ans.deny)
        else $error("other item open under code lock");

    chk_start_arms: assert property (start_press |=> message_a_shown)
        else $error("start key did not start counting");

    chk_msg_brief: assert property (
        s.msg == MSG_LOCK_ON && s.tick && s.msg_left == 2'h1 |=> s.msg == MSG_NONE)
        else $error("lock-on message did not expire");

    // fourth code digit taken, no tick that the idle timer could race
    sequence fourth_digit;
        key_in.valid && key_in.fn == KEY_DIGIT && s.dcnt == `KLT_CODE_DIGITS && !s.tick
        && (run_mode || s.lock != LK_UNLOCKED);
    endsequence

    chk_code_locks: assert property (
        fourth_digit ##0 (s.lock == LK_UNLOCKED && {s.dbuf[11:0], key_in.digit} == s.code)
        |=> lock == LK_CODE && msg == MSG_LOCK_ON && s.irq_stat[`KLT_IRQ_LOCK_ON])
        else $error("code did not lock");

    chk_code_unlocks: assert property (
        fourth_digit ##0 (s.lock == LK_CODE && {s.dbuf[11:0], key_in.digit} == s.code)
        |=> lock == LK_UNLOCKED && msg == MSG_LOCK_OFF && s.irq_stat[`KLT_IRQ_LOCK_OFF])
        else $error("code did not unlock");

    chk_timeout_unlocks: assert property (
        fourth_digit ##0 (s.lock == LK_TIMEOUT && {s.dbuf[11:0], key_in.digit} == s.code)
        |=> lock == LK_UNLOCKED)
        else $error("code did not leave timeout lock");

    chk_wrong_code: assert property (
        fourth_digit ##0 ({s.dbuf[11:0], key_in.digit} != s.code)
        |=> $stable(lock) && s.dcnt == 2'h0)
        else $error("wrong code changed the lock");

endmodule : klt_top

// ===== verification/klt_panel_model.sv
// ---------------------------------------------------------------
// operator keypad and flow pulse source
// ---------------------------------------------------------------
module klt_panel_model (
    input wire logic sys_clk,
    input wire klt_pkg::klt_menu_ans_type menu_ans,
    output klt_pkg::klt_key_type key_in,
    output klt_pkg::klt_menu_req_type menu_req,
    output logic pulse_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import klt_pkg::*;

    initial begin
        key_in = '0;
        menu_req = '0;
        pulse_in = 1'b0;
    end

    // one key press, valid for exactly one edge
    task automatic press(input klt_key_fn_type fn, input logic [3:0] d);
        @(posedge sys_clk);
        key_in <= '{valid: 1'b1, fn: fn, digit: d};
        @(posedge sys_clk);
        // released lines show junk, not the last key
        key_in <= '{valid: 1'b0, fn: KEY_MENU, digit: ~d};
        #1;
    endtask : press

    // four digits, most significant first
    task automatic keycode(input logic [15:0] c);
        for (int i = 3; i >= 0; i--) begin
            press(KEY_DIGIT, c[i*4 +: 4]);
        end
    endtask : keycode

    task automatic pulse();
        @(posedge sys_clk);
        pulse_in <= 1'b1;
        @(posedge sys_clk);
        pulse_in <= 1'b0;
        #1;
    endtask : pulse

    task automatic ask(input logic w, input klt_item_type it, output klt_menu_ans_type a);
        @(posedge sys_clk);
        menu_req <= '{valid: 1'b1, write: w, item: it};
        @(posedge sys_clk);
        menu_req <= '{valid: 1'b0, write: ~w, item: ITEM_OTHER};
        #1;
        a = menu_ans;
    endtask : ask
endmodule : klt_panel_model

// ===== verification/tb.sv
`include "klt_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import klt_pkg::*;

    logic sys_clk, sys_rst, run_mode, pulse_in, irq;
    klt_key_type key_in, key_out;
    klt_menu_req_type menu_req;
    klt_menu_ans_type menu_ans;
    klt_msg_type msg;
    klt_lock_type lock;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int checks = 0;
    int mismatches = 0;
    int key_seen = 0;
    int n, v1, cnt0;

    klt_top #(.TICK_CYCLES(20)) u_klt_top (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .run_mode(run_mode), .pulse_in(pulse_in),
        .key_in(key_in), .menu_req(menu_req), .key_out(key_out), .menu_ans(menu_ans),
        .msg(msg), .lock(lock), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    klt_panel_model u_klt_panel_model (
        .sys_clk(sys_clk), .menu_ans(menu_ans), .key_in(key_in), .menu_req(menu_req),
        .pulse_in(pulse_in)
    );

    initial begin
        sys_clk = 1'b0;
    end

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (key_out.valid === 1'b1) begin
            key_seen <= key_seen + 1;
        end
    end

    // ---------------------------------------------------------------
    // checking and bus tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge sys_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge sys_clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                dat = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rd

    task automatic put(input logic [7:0] a, input logic [31:0] dat);
        logic [1:0] rs;
        wr(a, dat, rs);
        check(rs, 2'h0);
    endtask : put

    task automatic get(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] dat;
        logic [1:0] rs;
        rd(a, dat, rs);
        check(dat, exp);
        check(rs, 2'h0);
    endtask : get

    task automatic menu(input logic w, input klt_item_type it, input logic [1:0] exp);
        klt_menu_ans_type a;
        u_klt_panel_model.ask(w, it, a);
        check(a, exp);
    endtask : menu

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        give_verdict();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        run_mode = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        get(`KLT_OFS_TIMEOUT, 32'h0);
        get(`KLT_OFS_CODE, 32'h1000);
        rd(8'h14, d, r);
        check(r, 2'h2);
        wr(`KLT_OFS_TIMEOUT, 32'h64, r);
        check(r, 2'h2);
        get(`KLT_OFS_TIMEOUT, 32'h0);
        put(`KLT_OFS_TIMEOUT, 32'h63);
        get(`KLT_OFS_TIMEOUT, 32'h63);
        run_mode <= 1'b1;
        u_klt_panel_model.keycode(16'h1234);
        check(lock, LK_UNLOCKED);
        u_klt_panel_model.keycode(16'h1000);
        check(lock, LK_CODE);
        check(msg, MSG_LOCK_ON);
        check(irq, 1'b0);
        get(`KLT_OFS_IRQ_STAT, 32'h4);
        put(`KLT_OFS_IRQ_MASK, 32'h4);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b1);
        put(`KLT_OFS_IRQ_STAT, 32'h4);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
        menu(1'b1, ITEM_BATCH, 2'b10);
        menu(1'b0, ITEM_WARN, 2'b10);
        menu(1'b1, ITEM_WARN, 2'b01);
        menu(1'b0, ITEM_OTHER, 2'b01);
        u_klt_panel_model.keycode(16'h1000);
        check(lock, LK_UNLOCKED);
        check(msg, MSG_LOCK_OFF);
        menu(1'b1, ITEM_OTHER, 2'b10);
        get(`KLT_OFS_IRQ_STAT, 32'h8);
        put(`KLT_OFS_IRQ_STAT, 32'hf);
        put(`KLT_OFS_IRQ_MASK, 32'h0);
        // idle timer: pulses keep it clear, stop freezes it
        put(`KLT_OFS_TIMEOUT, 32'h4);
        u_klt_panel_model.press(KEY_START, 4'h0);
        check(msg, MSG_A);
        rd(`KLT_OFS_STATUS, d, r);
        check(d[`KLT_ST_RUN_LSB], 1'b1);
        for (int i = 0; i < 10; i++) begin
            u_klt_panel_model.pulse();
            repeat (8) @(posedge sys_clk);
        end
        check(lock, LK_UNLOCKED);
        repeat (25) @(posedge sys_clk);
        u_klt_panel_model.press(KEY_STOP, 4'h0);
        rd(`KLT_OFS_STATUS, d, r);
        v1 = d[`KLT_ST_IDLE_LSB +: 7];
        check(v1 != 0, 1'b1);
        repeat (200) @(posedge sys_clk);
        rd(`KLT_OFS_STATUS, d, r);
        check(d[`KLT_ST_IDLE_LSB +: 7], v1);
        check(lock, LK_UNLOCKED);
        u_klt_panel_model.press(KEY_START, 4'h0);
        n = 0;
        while (lock !== LK_TIMEOUT && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        check(n <= (4 - v1) * 20 + 2, 1'b1);
        check(n > (3 - v1) * 20, 1'b1);
        check(lock, LK_TIMEOUT);
        #1;
        check(msg, MSG_SECURITY);
        get(`KLT_OFS_IRQ_STAT, 32'h3);
        // timeout lock: only digits get through
        cnt0 = key_seen;
        for (int f = 1; f < 7; f++) begin
            u_klt_panel_model.press(klt_key_fn_type'(f), 4'h0);
        end
        repeat (2) @(posedge sys_clk);
        check(key_seen, cnt0);
        menu(1'b0, ITEM_BATCH, 2'b01);
        u_klt_panel_model.keycode(16'h1000);
        repeat (2) @(posedge sys_clk);
        check(key_seen, cnt0 + 4);
        check(lock, LK_UNLOCKED);
        menu(1'b1, ITEM_OTHER, 2'b10);
        // a zero timeout never locks
        put(`KLT_OFS_TIMEOUT, 32'h0);
        u_klt_panel_model.press(KEY_START, 4'h0);
        repeat (150) @(posedge sys_clk);
        check(lock, LK_UNLOCKED);
        u_klt_panel_model.press(KEY_STOP, 4'h0);
        // a new stored code, then a reset brings back the defaults
        put(`KLT_OFS_CODE, 32'h2468);
        put(`KLT_OFS_TIMEOUT, 32'h5);
        u_klt_panel_model.keycode(16'h2468);
        check(lock, LK_CODE);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        get(`KLT_OFS_CODE, 32'h1000);
        get(`KLT_OFS_TIMEOUT, 32'h0);
        check(lock, LK_UNLOCKED);
        give_verdict();
    end
endmodule : tb
